// ==== hdl/boot_pkg.sv ====
/*
 Constants and types for the boot-mode selection and running-reset block.
 Assumes a single 200 MHz clock domain and an active-low power-up reset.
*/
// Function
// - Straps caught once at power-up pick the byte-wide boot source.
// - Code 000 boots as SPI slave, 001 as SPI master, 100 via link port 0.
// - Code 010 boots from byte-wide flash on the async memory interface.
// - Code 011 loads nothing; the core runs from internal ROM after reset.
// - Running reset clears core and peripherals, not PLL or DDR2, no boot.
// - The reset-out pin is also an input; driving it starts a running reset.
package boot_pkg;

	localparam logic [2:0] BOOT_CODE_SPI_SLAVE  = 3'h0;
	localparam logic [2:0] BOOT_CODE_SPI_MASTER = 3'h1;
	localparam logic [2:0] BOOT_CODE_ASYNC_FLASH = 3'h2;
	localparam logic [2:0] BOOT_CODE_ROM        = 3'h3;
	localparam logic [2:0] BOOT_CODE_LINK0      = 3'h4;
	localparam logic [2:0] BOOT_CODE_RESERVED   = 3'h5;

	localparam int CLK_PERIOD_NS        = 5;
	localparam int RUN_RESET_PULSE_NS   = 100;
	localparam int RUN_RESET_CYCLES     =
		(RUN_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BOOT_TIMEOUT_CYCLES  = 65536;

	typedef enum logic [2:0]
	{
		SRC_SPI_SLAVE,
		SRC_SPI_MASTER,
		SRC_ASYNC_FLASH,
		SRC_ROM,
		SRC_LINK0,
		SRC_NONE
	} boot_src_t;

	function automatic boot_src_t decode_straps(input logic [2:0] code);
		boot_src_t src;
		src = SRC_NONE;
		unique case (code)
			BOOT_CODE_SPI_SLAVE:  src = SRC_SPI_SLAVE;
			BOOT_CODE_SPI_MASTER: src = SRC_SPI_MASTER;
			BOOT_CODE_ASYNC_FLASH: src = SRC_ASYNC_FLASH;
			BOOT_CODE_ROM:        src = SRC_ROM;
			BOOT_CODE_LINK0:      src = SRC_LINK0;
			default:              src = SRC_NONE;
		endcase
		return src;
	endfunction

endpackage

// ==== hdl/boot_load_if.sv ====
/*
 Interface carrying the boot load request and its completion between the
 sequencer and the source-select module.
 Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface boot_load_if;
	import boot_pkg::*;
	logic      start;
	boot_src_t src;
	logic      busy;
	logic      done;

	modport seq (output start, output src, input busy, input done);
	modport sel (input start, input src, output busy, output done);
endinterface

// ==== hdl/boot_src_sel.sv ====
/*
 Routes one boot load request to the selected byte-wide source engine and
 reports completion back to the sequencer.
 Assumes each source engine answers start with a done pulse.
*/
`timescale 1ns/1ps
module boot_src_sel
	import boot_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	boot_load_if.sel        ld,
	input  wire logic [4:0] i_eng_done,
	output logic      [4:0] o_eng_start
);
	logic [4:0] start_reg;
	logic       busy_reg;
	logic       done_reg;
	logic [4:0] onehot;

	always_comb
	begin
		onehot = 5'h00;
		unique case (ld.src)
			SRC_SPI_SLAVE:  onehot = 5'h01;
			SRC_SPI_MASTER: onehot = 5'h02;
			SRC_ASYNC_FLASH: onehot = 5'h04;
			SRC_LINK0:      onehot = 5'h10;
			SRC_ROM:        onehot = 5'h00;
			SRC_NONE:       onehot = 5'h00;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			start_reg <= 5'h00;
			busy_reg  <= 1'b0;
			done_reg  <= 1'b0;
		end
		else
		begin
			start_reg <= 5'h00;
			done_reg  <= 1'b0;
			if (ld.start && !busy_reg)
			begin
				start_reg <= onehot;
				busy_reg  <= 1'b1;
			end
			else if (busy_reg && ((i_eng_done & onehot) != 5'h00))
			begin
				busy_reg <= 1'b0;
				done_reg <= 1'b1;
			end
		end
	end

	assign ld.busy     = busy_reg;
	assign ld.done     = done_reg;
	assign o_eng_start = start_reg;
endmodule

// ==== hdl/boot_mode_select_running_reset.sv ====
/*
 Boot-mode selection and running-reset control. Catches the straps after
 power-up reset, starts one byte-wide boot load unless ROM or a reserved code is selected, then releases the core unless the code is reserved.
 The reset-out pin is open-drain style: driven low by us while the core is
 held, and sensed as a running-reset request otherwise.
 A running reset holds core and peripherals only; PLL and DDR2 reset
 follow power-up reset alone.
 Assumes straps and pin input synchronous to i_clk.
*/
`timescale 1ns/1ps
module boot_mode_select_running_reset
	import boot_pkg::*;
#(
	parameter int RUN_RESET_LEN = RUN_RESET_CYCLES
)
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic [2:0] i_boot_select_straps,
	input  wire logic       i_reset_out_pin,
	input  wire logic [4:0] i_eng_done,
	output logic      [4:0] o_eng_start,
	output logic [2:0]      o_boot_src,
	output logic            o_boot_busy,
	output logic            o_core_rst_b,
	output logic            o_periph_rst_b,
	output logic            o_pll_ddr_rst_b,
	output logic            o_rom_exec,
	output logic            o_strap_err,
	output logic            o_reset_out_pin,
	output logic            o_reset_out_pin_oe
);
	typedef enum logic [2:0]
	{
		ST_CAPTURE,
		ST_LOAD_REQ,
		ST_LOADING,
		ST_RUN,
		ST_RUN_RESET
	} state_t;

	logic       rst_meta_reg;
	logic       rst_sync_reg;
	state_t     state_reg;
	boot_src_t  src_reg;
	logic       strap_err_reg;
	logic       core_rst_b_reg;
	logic       pll_rst_b_reg;
	logic       rom_exec_reg;
	logic       busy_reg;
	logic       periph_rst_b_reg;
	logic       pin_oe_reg;
	logic       pin_prev_reg;
	logic [15:0] cnt_reg;
	logic       pin_req;

	boot_load_if ld ();

	boot_src_sel u_sel
	(
		.i_clk       (i_clk),
		.i_rst_b     (rst_sync_reg),
		.ld          (ld),
		.i_eng_done  (i_eng_done),
		.o_eng_start (o_eng_start)
	);

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// PLL and DDR2 reset follows power-up reset only
	always_ff @(posedge i_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
			pll_rst_b_reg <= 1'b0;
		else
			pll_rst_b_reg <= 1'b1;
	end

	// Falling edge on the pin, only while we are not driving it
	assign pin_req = (state_reg == ST_RUN) && pin_prev_reg
		&& !i_reset_out_pin;

	always_ff @(posedge i_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
			pin_prev_reg <= 1'b1;
		else
			pin_prev_reg <= i_reset_out_pin;
	end

	// One boot per power-up; reserved codes stall here
	always_ff @(posedge i_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
			state_reg <= ST_CAPTURE;
		else
		begin
			unique case (state_reg)
				ST_CAPTURE:
					state_reg <= ST_LOAD_REQ;
				ST_LOAD_REQ:
				begin
					if (src_reg == SRC_ROM)
						state_reg <= ST_RUN;
					else if (src_reg == SRC_NONE)
						state_reg <= ST_LOAD_REQ;
					else
						state_reg <= ST_LOADING;
				end
				ST_LOADING:
				begin
					if (ld.done)
						state_reg <= ST_RUN;
				end
				ST_RUN:
				begin
					if (pin_req)
						state_reg <= ST_RUN_RESET;
				end
				ST_RUN_RESET:
				begin
					// No new load: straight back to run
					if (cnt_reg == 16'h0000)
						state_reg <= ST_RUN;
				end
			endcase
		end
	end

	// Straps caught once, after reset release
	always_ff @(posedge i_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			src_reg       <= SRC_NONE;
			strap_err_reg <= 1'b0;
		end
		else if (state_reg == ST_CAPTURE)
		begin
			src_reg       <= decode_straps(i_boot_select_straps);
			strap_err_reg <= (decode_straps(i_boot_select_straps)
				== SRC_NONE);
		end
	end

	always_ff @(posedge i_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
			rom_exec_reg <= 1'b0;
		else if ((state_reg == ST_LOAD_REQ) && (src_reg == SRC_ROM))
			rom_exec_reg <= 1'b1;
	end

	// Running reset length counter
	always_ff @(posedge i_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
			cnt_reg <= 16'h0000;
		else if ((state_reg == ST_RUN) && pin_req)
			cnt_reg <= 16'(RUN_RESET_LEN - 1);
		else if ((state_reg == ST_RUN_RESET) && (cnt_reg != 16'h0000))
			cnt_reg <= cnt_reg - 16'h0001;
	end

	assign ld.start = (state_reg == ST_LOAD_REQ) && (src_reg != SRC_ROM)
		&& (src_reg != SRC_NONE);
	assign ld.src   = src_reg;

	// Core and peripherals held outside RUN, PLL untouched
	always_ff @(posedge i_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
			core_rst_b_reg <= 1'b0;
		else
			core_rst_b_reg <= (state_reg == ST_RUN) && !pin_req;
	end

	always_ff @(posedge i_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
			periph_rst_b_reg <= 1'b0;
		else
			periph_rst_b_reg <= (state_reg == ST_RUN) && !pin_req;
	end

	// Pin pulled low by us exactly while the core is held
	always_ff @(posedge i_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
			pin_oe_reg <= 1'b1;
		else
			pin_oe_reg <= !((state_reg == ST_RUN) && !pin_req);
	end

	// Load in progress, from request to engine done
	always_ff @(posedge i_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
			busy_reg <= 1'b0;
		else
			busy_reg <= ld.start || ld.busy;
	end

	assign o_boot_src         = 3'(src_reg);
	assign o_boot_busy        = busy_reg;
	assign o_core_rst_b       = core_rst_b_reg;
	assign o_periph_rst_b     = periph_rst_b_reg;
	assign o_pll_ddr_rst_b    = pll_rst_b_reg;
	assign o_rom_exec         = rom_exec_reg;
	assign o_strap_err        = strap_err_reg;
	assign o_reset_out_pin    = 1'b0;
	assign o_reset_out_pin_oe = pin_oe_reg;
endmodule

// ==== tb/boot_asserts.sv ====
/*
 Checker for the boot-mode and running-reset block.
 Assumes it is bound to the top module.
*/
`timescale 1ns/1ps
module boot_asserts
	import boot_pkg::*;
#(
	parameter int RUN_RESET_LEN = RUN_RESET_CYCLES
)
(
	input wire logic       i_clk,
	input wire logic       i_rst_b,
	input wire logic       i_reset_out_pin,
	input wire logic [4:0] o_eng_start,
	input wire logic [2:0] o_boot_src,
	input wire logic       o_core_rst_b,
	input wire logic       o_periph_rst_b,
	input wire logic       o_pll_ddr_rst_b,
	input wire logic       o_rom_exec,
	input wire logic       o_reset_out_pin_oe
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	property p_src;
		o_eng_start != 5'h00 |-> o_eng_start == (5'h01 << o_boot_src);
	endproperty
	a_src: assert property (p_src) else $error("wrong engine started");
	property p_pulse;
		o_eng_start != 5'h00 |=> o_eng_start == 5'h00;
	endproperty
	a_pulse: assert property (p_pulse) else $error("start too long");
	property p_rom;
		o_rom_exec |-> o_boot_src == 3'(SRC_ROM) && o_eng_start == 5'h00;
	endproperty
	a_rom: assert property (p_rom) else $error("rom run with load");
	property p_keep;
		$fell(o_core_rst_b) |-> o_pll_ddr_rst_b ##1 (o_eng_start == 5'h00)[*8];
	endproperty
	a_keep: assert property (p_keep) else $error("running reset hit pll or boot");
	property p_req;
		o_core_rst_b && $fell(i_reset_out_pin) |-> ##[1:2] !o_core_rst_b
			&& !o_periph_rst_b;
	endproperty
	a_req: assert property (p_req) else $error("pin request ignored");
	property p_oe;
		!o_core_rst_b |-> o_reset_out_pin_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("pin not driven in reset");
endmodule

// ==== tb/boot_engines.sv ====
/*
 Model of the boot source engines: answers a start with a done pulse.
 Assumes one start at a time; delay set by the bench.
*/
`timescale 1ns/1ps
module boot_engines
(
	input  wire logic       i_clk,
	input  wire logic [4:0] i_start,
	input  wire logic [3:0] i_delay,
	output logic      [4:0] o_done
);
	logic [4:0] pend_reg = 5'h00;
	logic [3:0] cnt_reg = 4'h0;
	initial o_done = 5'h00;
	always @(posedge i_clk)
	begin
		o_done <= 5'h00;
		if (i_start != 5'h00)
		begin
			pend_reg <= i_start;
			cnt_reg <= i_delay;
		end
		else if (pend_reg != 5'h00 && cnt_reg == 4'h0)
		begin
			o_done <= pend_reg;
			pend_reg <= 5'h00;
		end
		else if (pend_reg != 5'h00)
			cnt_reg <= cnt_reg - 4'h1;
	end
endmodule

// ==== tb/boot_mode_select_running_reset_test.sv ====
/*
 Bench for the boot-mode and running-reset block.
 Assumes the engine model and the bound checker.
*/
`timescale 1ns/1ps
module boot_mode_select_running_reset_test;
	typedef struct {logic [2:0] c; logic [4:0] e; logic r;} row_t;
	row_t       rows[5] = '{'{3'h0, 5'h01, 1'b0}, '{3'h1, 5'h02, 1'b0},
		'{3'h2, 5'h04, 1'b0}, '{3'h3, 5'h00, 1'b1}, '{3'h4, 5'h10, 1'b0}};
	logic       clk = 0, rst_b = 0, pull = 0, busy, core, per, pll, rom;
	logic       err, opin, oe;
	logic [2:0] straps = 3'h0, src;
	logic [3:0] dly = 4'h0;
	logic [4:0] start, done, seen;
	int         mismatches = 0, checks = 0, n, m, k;
	localparam int RUN_LEN = 2;
	wire        pin = ~((oe & ~opin) | pull);
	always #2.5 clk = ~clk;
	boot_mode_select_running_reset #(.RUN_RESET_LEN(RUN_LEN))
		boot_mode_select_running_reset_inst (.i_clk(clk), .i_rst_b(rst_b),
		.i_boot_select_straps(straps), .i_reset_out_pin(pin),
		.i_eng_done(done), .o_eng_start(start), .o_boot_src(src),
		.o_boot_busy(busy), .o_core_rst_b(core), .o_periph_rst_b(per),
		.o_pll_ddr_rst_b(pll), .o_rom_exec(rom), .o_strap_err(err),
		.o_reset_out_pin(opin), .o_reset_out_pin_oe(oe));
	boot_engines boot_engines_inst (.i_clk(clk), .i_start(start),
		.i_delay(dly), .o_done(done));
	task cmp(string nm, logic [4:0] e, logic [4:0] s);
		checks++;
		if (e !== s)
		begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task bound(int used, int lim);
		if (used == lim)
		begin
			cmp("timeout", 5'h00, 5'h01);
			results();
		end
	endtask
	task boot(logic [2:0] code, logic [3:0] d);
		rst_b = 0;
		straps = code;
		dly = d;
		seen = 5'h00;
		repeat (3) @(negedge clk);
		rst_b = 1;
		for (n = 0; core !== 1'b1 && err !== 1'b1 && n < 200; n++)
		begin
			@(negedge clk);
			seen = seen | start;
		end
		bound(n, 200);
		cmp("pll", 5'h01, {4'h0, pll});
	endtask
	initial
	begin
		@(negedge clk);
		foreach (rows[i])
		begin
			boot(rows[i].c, 4'h0);
			cmp("engine", rows[i].e, seen);
			cmp("src", {2'h0, rows[i].c}, {2'h0, src});
			cmp("rom", {4'h0, rows[i].r}, {4'h0, rom});
			$display("row %0d done", i);
		end
		boot(3'h2, 4'h9);
		cmp("slow", 5'h04, seen);
		// Edge detector needs one high sample of the released pin
		@(negedge clk);
		pull = 1;
		@(negedge clk);
		pull = 0;
		for (n = 0; core !== 1'b0 && n < 5; n++)
			@(negedge clk);
		bound(n, 5);
		for (m = 0; core === 1'b0 && m < 50; m++)
		begin
			cmp("keep", 5'h01, {4'h0, pll});
			cmp("noboot", 5'h00, start);
			cmp("perlow", 5'h00, {4'h0, per});
			@(negedge clk);
		end
		bound(m, 50);
		cmp("runlen", 5'(RUN_LEN + 1), m[4:0]);
		cmp("per", 5'h01, {4'h0, per});
		$display("running reset done");
		for (k = 5; k < 8; k += 2)
		begin
			boot(k[2:0], 4'h0);
			for (n = 0; n < 10; n++)
			begin
				@(negedge clk);
				seen = seen | start;
			end
			cmp("err", 5'h01, {4'h0, err});
			cmp("held", 5'h00, {4'h0, core} | seen);
		end
		$display("reserved done");
		results();
	end
endmodule

bind boot_mode_select_running_reset boot_asserts
	#(.RUN_RESET_LEN(RUN_RESET_LEN)) boot_asserts_inst (.*);
